// ===== sies_defs.vh
// Purpose: Constants for the sync input edge-sense status block
// Assumes: 8-bit register port, byte offsets on an 8-bit address
// Notes: Definitions only, no logic
`ifndef SIES_DEFS_VH
`define SIES_DEFS_VH

// Register offsets
`define SIES_ADDR_W 8
`define SIES_DATA_W 8
`define SIES_STATUS_OFS 8'h00
`define SIES_CONN_OFS 8'h01

// Status register field positions
`define SIES_VEDGE_BIT 7
`define SIES_HEDGE_BIT 6
`define SIES_CEDGE_BIT 5
`define SIES_HFEDGE_BIT 4
`define SIES_VFEDGE_BIT 3
`define SIES_PREQ_BIT 2
`define SIES_IHI_BIT 1
`define SIES_IVI_BIT 0

// Flag bits that software may clear, per channel
`define SIES_FLAG_MASK_CH0 8'hfc
`define SIES_FLAG_MASK_CH1 8'he4

// Input connection register field positions
`define SIES_CONN_HSRC_BIT 0
`define SIES_CONN_HINV_BIT 1
`define SIES_CONN_VSRC_BIT 2
`define SIES_CONN_VINV_BIT 3
`define SIES_CONN_MASK 8'h0f

// Reset values
`define SIES_FLAGS_RST 8'h00
`define SIES_CONN_RST 8'h00
`define SIES_RDATA_RST 8'h00

// Timing counts
`define SIES_SYNC_STAGES 2
`define SIES_EDGE_TO_FLAG_CYC 1

`endif

// ===== sies_edge_det.v
// Purpose: Two-flop synchroniser with rising and falling edge detection
// Assumes: One system clock, synchronous active-high reset
// Notes: Edge pulses are combinational and last one cycle
`timescale 1ns/10ps
`default_nettype none

module sies_edge_det
(
  input wire sys_clk_in,
  input wire srst_in,
  input wire pin_in,
  output wire level_out,
  output wire rise_out,
  output wire fall_out
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  // First stage feeds only the second; it may be metastable
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Low sample followed by high sample is a rising edge
  assign rise_out = sync_q & ~prev_q;
  assign fall_out = ~sync_q & prev_q;
  assign level_out = sync_q;

endmodule // sies_edge_det

`default_nettype wire

// ===== sies_status.v
// Purpose: Edge-sense and level status register for the sync inputs
// Assumes: Pins asynchronous to sys_clk_in; mask interval from the timer
// Notes: Register reads return data in the cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
`include "sies_defs.vh"

// Contract
// R01 - Vertical sync pin rise sets bit 7
// R02 - Horizontal sync pin rise sets bit 6
// R03 - Composite sync pin rise sets bit 5
// R04 - Channel 0: horizontal flyback rise sets bit 4
// R05 - Channel 0: vertical flyback rise sets bit 3
// R06 - Channel 1: bits 4,3 read zero, unwritable
// R07 - Flag clears on zero write after reading one
// R08 - 2fH modification condition sets bit 2
// R09 - Horizontal input edge inside mask interval detected
// R10 - Bit 1 shows horizontal input level
// R11 - Horizontal level taken after source and inversion
// R12 - Bit 0 shows vertical input level
// R13 - Writing one never sets a flag
// R14 - Levels follow pins; flags reset to zero (levels read zero in reset: their synchronisers are reset)
// R15 - Synchronise pins; flag set cycle after edge
module sies_status
#(
  parameter CHANNEL_ID = 0
)
(
  input wire sys_clk_in,
  input wire srst_in,
  input wire [`SIES_ADDR_W-1:0] reg_addr_in,
  input wire [`SIES_DATA_W-1:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output wire [`SIES_DATA_W-1:0] reg_rdata_out,
  input wire vert_sync_in_pin_in,
  input wire horiz_sync_in_pin_in,
  input wire composite_sync_in_pin_in,
  input wire horiz_flyback_in_pin_in,
  input wire vert_flyback_in_pin_in,
  input wire mask_interval_in,
  output wire [`SIES_DATA_W-1:0] sync_edge_sense_status_out,
  output wire internal_horiz_input_out,
  output wire internal_vert_input_out
);

  // Address decode shared by read and write paths
  function sies_hit;
    input [`SIES_ADDR_W-1:0] addr;
    input [`SIES_ADDR_W-1:0] ofs;
    begin
      sies_hit = (addr == ofs);
    end
  endfunction

  // Source select, then phase inversion; both internal inputs share it
  function sies_sel_inv;
    input use_comp;
    input invert;
    input comp_level;
    input own_level;
    begin
      sies_sel_inv = (use_comp ? comp_level : own_level) ^ invert;
    end
  endfunction

  // Clearable flag bits depend on the channel
  localparam [`SIES_DATA_W-1:0] FLAG_MASK =
    (CHANNEL_ID == 0) ? `SIES_FLAG_MASK_CH0 : `SIES_FLAG_MASK_CH1;

  wire vsync_level;
  wire vsync_rise;
  wire hsync_level;
  wire hsync_rise;
  wire csync_level;
  wire csync_rise;
  wire hfback_rise;
  wire vfback_rise;

  reg [`SIES_DATA_W-1:0] flags_q;
  reg [`SIES_DATA_W-1:0] flags_d;
  reg [`SIES_DATA_W-1:0] armed_q;
  reg [`SIES_DATA_W-1:0] armed_d;
  reg [`SIES_DATA_W-1:0] conn_q;
  reg [`SIES_DATA_W-1:0] conn_d;
  reg [`SIES_DATA_W-1:0] rdata_q;
  reg [`SIES_DATA_W-1:0] rdata_d;
  reg ihi_q;
  reg ivi_q;
  reg mask_q;

  reg [`SIES_DATA_W-1:0] set_vec;
  reg [`SIES_DATA_W-1:0] clr_vec;
  reg [`SIES_DATA_W-1:0] status_view;
  reg ihi_d;
  reg ivi_d;
  reg ihi_toggle;

  wire status_wr;
  wire status_rd;
  wire conn_wr;
  wire conn_rd;

  // Synchronise each pin and find its rising edge [R15]
  sies_edge_det u_vsync
  (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .pin_in(vert_sync_in_pin_in),
    .level_out(vsync_level),
    .rise_out(vsync_rise),
    .fall_out()
  );

  sies_edge_det u_hsync
  (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .pin_in(horiz_sync_in_pin_in),
    .level_out(hsync_level),
    .rise_out(hsync_rise),
    .fall_out()
  );

  sies_edge_det u_csync
  (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .pin_in(composite_sync_in_pin_in),
    .level_out(csync_level),
    .rise_out(csync_rise),
    .fall_out()
  );

  sies_edge_det u_hfback
  (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .pin_in(horiz_flyback_in_pin_in),
    .level_out(),
    .rise_out(hfback_rise),
    .fall_out()
  );

  sies_edge_det u_vfback
  (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .pin_in(vert_flyback_in_pin_in),
    .level_out(),
    .rise_out(vfback_rise),
    .fall_out()
  );

  assign status_wr = reg_wr_in & sies_hit(reg_addr_in, `SIES_STATUS_OFS);
  assign status_rd = reg_rd_in & sies_hit(reg_addr_in, `SIES_STATUS_OFS);
  assign conn_wr = reg_wr_in & sies_hit(reg_addr_in, `SIES_CONN_OFS);
  assign conn_rd = reg_rd_in & sies_hit(reg_addr_in, `SIES_CONN_OFS);

  // Internal signals: source select, then phase inversion
  always @*
  begin
    ihi_d = sies_sel_inv(conn_q[`SIES_CONN_HSRC_BIT], conn_q[`SIES_CONN_HINV_BIT],
      csync_level, hsync_level); // [R11]
    ivi_d = sies_sel_inv(conn_q[`SIES_CONN_VSRC_BIT], conn_q[`SIES_CONN_VINV_BIT],
      csync_level, vsync_level); // [R12]
    // Either edge of the horizontal input counts
    ihi_toggle = (ihi_d != ihi_q);
  end

  // Hardware set requests, aligned to the edge cycle
  always @*
  begin
    set_vec = {`SIES_DATA_W{1'b0}};
    set_vec[`SIES_VEDGE_BIT] = vsync_rise; // [R01]
    set_vec[`SIES_HEDGE_BIT] = hsync_rise; // [R02]
    set_vec[`SIES_CEDGE_BIT] = csync_rise; // [R03]
    set_vec[`SIES_HFEDGE_BIT] = hfback_rise; // [R04]
    set_vec[`SIES_VFEDGE_BIT] = vfback_rise; // [R05]
    set_vec[`SIES_PREQ_BIT] = ihi_toggle & mask_q; // [R08] [R09]
    set_vec = set_vec & FLAG_MASK; // [R06]
  end

  // Clear only bits armed by an earlier read and written as zero
  always @*
  begin
    clr_vec = {`SIES_DATA_W{1'b0}};
    if (status_wr)
    begin
      clr_vec = armed_q & ~reg_wdata_in & FLAG_MASK; // [R07] [R13]
    end
  end

  // Set wins over clear, so an edge in the clearing cycle is kept
  always @*
  begin
    flags_d = ((flags_q & ~clr_vec) | set_vec) & FLAG_MASK; // [R07] [R15]
  end

  // Arm on reading a one; any write to the register disarms it
  always @*
  begin
    armed_d = armed_q;
    if (status_wr)
    begin
      armed_d = {`SIES_DATA_W{1'b0}};
    end
    if (status_rd)
    begin
      armed_d = armed_d | (flags_q & FLAG_MASK); // [R07]
    end
    // A flag already gone cannot stay armed
    armed_d = armed_d & flags_d;
  end

  // Input connection control register
  always @*
  begin
    conn_d = conn_q;
    if (conn_wr)
    begin
      conn_d = reg_wdata_in & `SIES_CONN_MASK;
    end
  end

  // Status view: flags above, live levels in the two low bits
  always @*
  begin
    status_view = flags_q & FLAG_MASK; // [R06]
    status_view[`SIES_IHI_BIT] = ihi_q; // [R10]
    status_view[`SIES_IVI_BIT] = ivi_q; // [R12]
  end

  // Read data stands for one cycle; unmapped reads return zero
  always @*
  begin
    rdata_d = `SIES_RDATA_RST;
    if (status_rd)
    begin
      rdata_d = status_view;
    end
    else if (conn_rd)
    begin
      rdata_d = conn_q;
    end
  end

  // Flags and their arming move together, so a clear never sees stale arming
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      flags_q <= `SIES_FLAGS_RST; // [R14]
      armed_q <= `SIES_FLAGS_RST;
    end
    else
    begin
      flags_q <= flags_d;
      armed_q <= armed_d;
    end
  end

  // Connection register
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      conn_q <= `SIES_CONN_RST;
    end
    else
    begin
      conn_q <= conn_d;
    end
  end

  // Read data register
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      rdata_q <= `SIES_RDATA_RST;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // Mask register
  always @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      mask_q <= 1'b0;
    end
    else
    begin
      // Delayed to line up with the synchronised edge
      mask_q <= mask_interval_in;
    end
  end

  // Level registers are not reset, but their synchronisers are: they read zero in reset
  always @(posedge sys_clk_in)
  begin
    ihi_q <= ihi_d; // [R14]
    ivi_q <= ivi_d;
  end

  assign reg_rdata_out = rdata_q;
  assign sync_edge_sense_status_out = status_view;
  assign internal_horiz_input_out = ihi_q;
  assign internal_vert_input_out = ivi_q;

endmodule // sies_status

`default_nettype wire

// ===== sies_status_checker.sv
// Purpose: Port assertions for the sync edge-sense status block
// Assumes: Pins change just after a rising clock edge
// Notes: Flag latency is three edges from a sampled pin rise
`timescale 1ns/10ps
`default_nettype none
module sies_status_checker #(parameter CHANNEL_ID = 0)
(
  input wire sys_clk_in,
  input wire srst_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire vert_sync_in_pin_in,
  input wire horiz_sync_in_pin_in,
  input wire composite_sync_in_pin_in,
  input wire horiz_flyback_in_pin_in,
  input wire vert_flyback_in_pin_in,
  input wire mask_interval_in,
  input wire [7:0] sync_edge_sense_status_out,
  input wire internal_horiz_input_out,
  input wire internal_vert_input_out
);
  wire [7:0] st = sync_edge_sense_status_out;
  wire wr0 = reg_wr_in && reg_addr_in == 8'h00;
  logic [2:0] age_q;
  logic rd_q;
  logic arm_q;
  // Shadow of the connection register and cycles since it was last written
  logic [3:0] cs_q;
  logic [2:0] cage_q;
  wire cwr = reg_wr_in && reg_addr_in == 8'h01;
  // Tracks the read-then-write arming of bit 7 only, to keep the model small
  wire armed = arm_q || (rd_q && reg_rdata_out[7]);
  always @(posedge sys_clk_in)
  begin
    age_q <= srst_in ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
    rd_q <= !srst_in && reg_rd_in && reg_addr_in == 8'h00;
    arm_q <= !srst_in && !wr0 && armed;
    cs_q <= srst_in ? 4'h0 : cwr ? reg_wdata_in[3:0] : cs_q;
    cage_q <= (srst_in || cwr) ? 3'h0 : cage_q + {2'h0, cage_q != 3'h7};
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);
  sequence s_rise(x); !x ##1 x; endsequence
  property p_vedge; s_rise(vert_sync_in_pin_in) |-> ##3 st[7]; endproperty
  a_vedge: assert property (p_vedge) else $error("vert edge flag");
  property p_hedge; s_rise(horiz_sync_in_pin_in) |-> ##3 st[6]; endproperty
  a_hedge: assert property (p_hedge) else $error("horiz edge flag");
  property p_cedge; s_rise(composite_sync_in_pin_in) |-> ##3 st[5]; endproperty
  a_cedge: assert property (p_cedge) else $error("comp edge flag");
  property p_hfedge; s_rise(horiz_flyback_in_pin_in) |-> ##3 (CHANNEL_ID != 0 || st[4]); endproperty
  a_hfedge: assert property (p_hfedge) else $error("hfb edge flag");
  property p_rsvd; CHANNEL_ID == 0 || st[4:3] == 2'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits");
  property p_cause; age_q == 3'h7 && $rose(st[7]) |-> $past(vert_sync_in_pin_in, 3) && !$past(vert_sync_in_pin_in, 4); endproperty
  a_cause: assert property (p_cause) else $error("flag without edge");
  property p_clear; age_q == 3'h7 && wr0 && armed && !reg_wdata_in[7] && !($past(vert_sync_in_pin_in, 2) && !$past(vert_sync_in_pin_in, 3)) |=> !st[7]; endproperty
  a_clear: assert property (p_clear) else $error("armed clear");
  property p_preq; age_q == 3'h7 && $changed(internal_horiz_input_out) && $past(mask_interval_in) && $past(mask_interval_in, 2) |-> ##[0:2] st[2]; endproperty
  a_preq: assert property (p_preq) else $error("pre-eq flag");
  property p_level; st[1:0] == {internal_horiz_input_out, internal_vert_input_out}; endproperty
  a_level: assert property (p_level) else $error("level bits");
  property p_hlevel; age_q == 3'h7 && cage_q == 3'h7 |-> internal_horiz_input_out ==
    ((cs_q[0] ? $past(composite_sync_in_pin_in, 3) : $past(horiz_sync_in_pin_in, 3)) ^ cs_q[1]);
  endproperty
  a_hlevel: assert property (p_hlevel) else $error("horiz level");
  property p_vlevel; age_q == 3'h7 && cage_q == 3'h7 |-> internal_vert_input_out ==
    ((cs_q[2] ? $past(composite_sync_in_pin_in, 3) : $past(vert_sync_in_pin_in, 3)) ^ cs_q[3]);
  endproperty
  a_vlevel: assert property (p_vlevel) else $error("vert level");
endmodule // sies_status_checker
`default_nettype wire

// ===== sies_sync_src.sv
// Purpose: External video sync source driving the five sync pins
// Assumes: Bench requests levels; the source moves them after a rising edge
// Notes: Pulses shorter than a cycle are never produced
`timescale 1ns/10ps
`default_nettype none
module sies_sync_src
(
  input wire sys_clk_in,
  input wire [4:0] req_in,
  output wire vert_sync_in_pin_in,
  output wire horiz_sync_in_pin_in,
  output wire composite_sync_in_pin_in,
  output wire horiz_flyback_in_pin_in,
  output wire vert_flyback_in_pin_in
);
  logic [4:0] lv_q = 5'h00;
  always @(posedge sys_clk_in) lv_q <= req_in;
  assign {vert_sync_in_pin_in, horiz_sync_in_pin_in, composite_sync_in_pin_in} = lv_q[4:2];
  assign {horiz_flyback_in_pin_in, vert_flyback_in_pin_in} = lv_q[1:0];
endmodule // sies_sync_src
`default_nettype wire

// ===== tb_sies_status.sv
// Purpose: Self-checking bench for the sync edge-sense status block
// Assumes: Both channel instances share one register port
// Notes: Fixed waits follow the synchroniser depth
`timescale 1ns/10ps
`default_nettype none
module tb_sies_status;
  logic sys_clk_in, srst_in, reg_wr_in, reg_rd_in, mask_interval_in;
  logic internal_horiz_input_out, internal_vert_input_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, sync_edge_sense_status_out, st1;
  logic [7:0] conn, ex;
  logic [4:0] req_in, pins;
  wire vert_sync_in_pin_in, horiz_sync_in_pin_in, composite_sync_in_pin_in;
  wire horiz_flyback_in_pin_in, vert_flyback_in_pin_in;
  int errors, n_compared, i;
  wire [7:0] lvl = {6'h00, internal_horiz_input_out, internal_vert_input_out};
  // Rows: connection value, pin pattern, expected status
  logic [20:0] rows [9] = '{{8'h00, 5'h10, 8'h81}, {8'h00, 5'h08, 8'h42}, {8'h00, 5'h04, 8'h20},
    {8'h00, 5'h02, 8'h10}, {8'h00, 5'h01, 8'h08}, {8'h03, 5'h04, 8'h20}, {8'h04, 5'h04, 8'h21},
    {8'h0b, 5'h10, 8'h82}, {8'h00, 5'h1f, 8'hfb}};
  sies_sync_src sies_sync_src_i (.*);
  sies_status sies_status_i (.*);
  sies_status #(.CHANNEL_ID(1)) sies_status_ch1_i (.reg_rdata_out(), .sync_edge_sense_status_out(st1),
    .internal_horiz_input_out(), .internal_vert_input_out(), .*);
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] got);
    n_compared++;
    if (got !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(nm, e, reg_rdata_out);
  endtask
  task automatic rst;
    @(posedge sys_clk_in);
    srst_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    // Level bits read zero in reset and are masked off here
    #1 chk("reset flags", 8'h00, sync_edge_sense_status_out & 8'hfc);
  endtask
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    srst_in = 1'b1;
    {reg_wr_in, reg_rd_in, mask_interval_in, reg_addr_in, reg_wdata_in, req_in} = '0;
    rst();
    for (i = 0; i < 9; i++)
    begin
      {conn, pins, ex} = rows[i];
      wr(8'h01, conn);
      rdc("conn", 8'h01, conn);
      @(posedge sys_clk_in);
      req_in <= pins;
      repeat (6) @(posedge sys_clk_in);
      #1 chk("ch1 status", ex & 8'he7, st1);
      chk("ch0 view", ex, sync_edge_sense_status_out);
      chk("levels", ex & 8'h03, lvl);
      rdc("status", 8'h00, ex);
      wr(8'h00, 8'h00);
      rdc("cleared", 8'h00, ex & 8'h03);
      @(posedge sys_clk_in);
      req_in <= 5'h00;
      repeat (5) @(posedge sys_clk_in);
    end
    wr(8'h01, 8'hff);
    rdc("conn", 8'h01, 8'h0f);
    wr(8'h01, 8'h00);
    wr(8'h05, 8'hff);
    rdc("unmapped", 8'h05, 8'h00);
    wr(8'h00, 8'hff);
    rdc("one write", 8'h00, 8'h00);
    @(posedge sys_clk_in);
    req_in <= 5'h10;
    repeat (2) @(posedge sys_clk_in);
    req_in <= 5'h00;
    repeat (4) @(posedge sys_clk_in);
    wr(8'h00, 8'h00);
    rdc("unarmed clear", 8'h00, 8'h80);
    wr(8'h00, 8'h7f);
    rdc("armed clear", 8'h00, 8'h00);
    // Mask held well past both horizontal edges so both land inside it
    @(posedge sys_clk_in);
    mask_interval_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    req_in <= 5'h08;
    repeat (2) @(posedge sys_clk_in);
    req_in <= 5'h00;
    repeat (6) @(posedge sys_clk_in);
    mask_interval_in <= 1'b0;
    rdc("pre-eq", 8'h00, 8'h44);
    rst();
    print_verdict();
  end
endmodule // tb_sies_status
bind sies_status sies_status_checker #(.CHANNEL_ID(CHANNEL_ID)) sies_status_checker_i (.*);
`default_nettype wire
